// ---- verilog/sideband_params.svh ----
`ifndef SIDEBAND_PARAMS_SVH
`define SIDEBAND_PARAMS_SVH

// register offsets
`define OFF_GPIO9_CFG    8'h1a
`define OFF_GPIO0_CFG    8'h1d
`define OFF_GPIO12_CFG   8'h1e
`define OFF_GPIO3_CFG    8'h1f
`define OFF_REG56_CFG    8'h20
`define OFF_REG78_CFG    8'h21
`define OFF_BC_CTRL      8'h23
`define OFF_SB_CTRL      8'h43
`define OFF_IN_LOW       8'h6e
`define OFF_IN_HIGH      8'h6f

// reset values
`define RST_CFG          8'h00
`define RST_CTRL         8'h00

// local gpio nibble codes
`define CFG_OUT_LOW      4'h1
`define CFG_OUT_HIGH     4'h9
`define CFG_INPUT        4'h3

// back-channel control bit positions
`define BC_RATE_SEL_BIT  6
`define BC_HIGH_RATE_BIT 4

// oscillator divider end counts (divide by 4, 2, 1)
`define DIV_END_4        2'd3
`define DIV_END_2        2'd1
`define DIV_END_1        2'd0

// back-channel frame length in bit times, and sample spacing per mode
`define BC_FRAME_BITS    5'd30
`define SAMP_INT_NORMAL  5'd30
`define SAMP_INT_4PIN    5'd5
`define SAMP_INT_2PIN    5'd3
`define SAMP_INT_1PIN    5'd2

// reverse spi sample buffer
`define BUF_DEPTH        8
`define BUF_AW           3

// input synchroniser width
`define SYNC_W           22

`endif

// ---- verilog/sideband_pkg.sv ----
`default_nettype none
package sideband_pkg;

    // sideband mode field codes
    typedef enum logic [2:0] {
        SB_NORMAL   = 3'h0,
        SB_FAST_1   = 3'h1,
        SB_FAST_2   = 3'h2,
        SB_FAST_4   = 3'h3,
        SB_SPI_FWD  = 3'h6,
        SB_SPI_REV  = 3'h7
    } sb_mode_t;

    // spi signals sampled by the far end and carried in forward frames
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic ss_n;
    } fwd_spi_t;

    // content of one back-channel frame
    typedef struct packed {
        logic        ssLevel;
        logic        spiValid;
        logic        spiMosi;
        logic [23:0] gpioSamples;
        logic [2:0]  mode;
    } bc_frame_t;

endpackage
`default_nettype wire

// ---- verilog/sideband_spi_gpio_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sideband_params.svh"

module sideband_spi_gpio_channel
    import sideband_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            nrst,
    input  wire logic [7:0]      regAddr,
    input  wire logic            regWr,
    input  wire logic [7:0]      regWrData,
    input  wire logic            regRd,
    output logic      [7:0]      regRdData,
    input  wire logic            twoLaneMode,
    input  wire logic [9:0]      gpioPinIn,
    output logic      [9:0]      gpioPinOut,
    output logic      [9:0]      gpioPinOe_n,
    output logic      [3:0]      audioDataOut,
    input  wire logic [3:0]      fastGpioIn,
    input  wire logic            pixelClkIn,
    input  wire fwd_spi_t        fwdSpiIn,
    output logic                 fwdSclkOut,
    output logic                 fwdMosiOut,
    output logic                 fwdSsOut_n,
    input  wire logic            spiSsIn_n,
    input  wire logic            spiSclkIn,
    input  wire logic            spiMosiIn,
    input  wire logic            remoteMisoIn,
    output logic                 spiMisoOut,
    output logic                 bcFrameValid,
    output bc_frame_t            bcFrame
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [`SYNC_W-1:0] rawIn;
    logic [`SYNC_W-1:0] sync1_q;
    logic [`SYNC_W-1:0] sync2_q;
    logic [`SYNC_W-1:0] sync3_q;
    logic [`SYNC_W-1:0] stable_q;
    logic [`SYNC_W-1:0] stable_d;

    assign rawIn = {remoteMisoIn, spiMosiIn, spiSclkIn, spiSsIn_n, fwdSpiIn.ss_n,
                    fwdSpiIn.mosi, fwdSpiIn.sclk, pixelClkIn, fastGpioIn, gpioPinIn};

    // accept a change once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < `SYNC_W; i++)
        begin
            stable_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : stable_q[i];
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q  <= '0;
            sync2_q  <= '0;
            sync3_q  <= '0;
            stable_q <= '0;
        end
        else
        begin
            sync1_q  <= rawIn;
            sync2_q  <= sync1_q;
            sync3_q  <= sync2_q;
            stable_q <= stable_d;
        end
    end

    logic [9:0] gpioLvl;
    logic [3:0] fastLvl;
    logic       pclkLvl;
    logic       fSclkLvl;
    logic       fMosiLvl;
    logic       fSsLvl;
    logic       rSsLvl;
    logic       rSclkLvl;
    logic       rMosiLvl;
    logic       misoLvl;

    assign gpioLvl  = stable_q[9:0];
    assign fastLvl  = stable_q[13:10];
    assign pclkLvl  = stable_q[14];
    assign fSclkLvl = stable_q[15];
    assign fMosiLvl = stable_q[16];
    assign fSsLvl   = stable_q[17];
    assign rSsLvl   = stable_q[18];
    assign rSclkLvl = stable_q[19];
    assign rMosiLvl = stable_q[20];
    assign misoLvl  = stable_q[21];

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0] gpio9Cfg_q, gpio0Cfg_q, gpio12Cfg_q, gpio3Cfg_q;
    logic [7:0] reg56Cfg_q, reg78Cfg_q, bcCtrl_q, sbCtrl_q;
    logic [7:0] gpio9Cfg_d, gpio0Cfg_d, gpio12Cfg_d, gpio3Cfg_d;
    logic [7:0] reg56Cfg_d, reg78Cfg_d, bcCtrl_d, sbCtrl_d;
    logic [7:0] regRdData_q, regRdData_d;
    logic [7:0] inLow, inHigh;
    logic [9:0] inLvl;

    // writes store, reads return one cycle later, unmapped reads zero
    always_comb
    begin
        gpio9Cfg_d  = gpio9Cfg_q;
        gpio0Cfg_d  = gpio0Cfg_q;
        gpio12Cfg_d = gpio12Cfg_q;
        gpio3Cfg_d  = gpio3Cfg_q;
        reg56Cfg_d  = reg56Cfg_q;
        reg78Cfg_d  = reg78Cfg_q;
        bcCtrl_d    = bcCtrl_q;
        sbCtrl_d    = sbCtrl_q;
        regRdData_d = regRdData_q;
        if (regWr)
        begin
            case (regAddr)
                `OFF_GPIO9_CFG:  gpio9Cfg_d  = regWrData;
                `OFF_GPIO0_CFG:  gpio0Cfg_d  = regWrData;
                `OFF_GPIO12_CFG: gpio12Cfg_d = regWrData;
                `OFF_GPIO3_CFG:  gpio3Cfg_d  = regWrData;
                `OFF_REG56_CFG:  reg56Cfg_d  = regWrData;
                `OFF_REG78_CFG:  reg78Cfg_d  = regWrData;
                `OFF_BC_CTRL:    bcCtrl_d    = regWrData;
                `OFF_SB_CTRL:    sbCtrl_d    = regWrData;
                default:         ;
            endcase
        end
        if (regRd)
        begin
            case (regAddr)
                `OFF_GPIO9_CFG:  regRdData_d = gpio9Cfg_q;
                `OFF_GPIO0_CFG:  regRdData_d = gpio0Cfg_q;
                `OFF_GPIO12_CFG: regRdData_d = gpio12Cfg_q;
                `OFF_GPIO3_CFG:  regRdData_d = gpio3Cfg_q;
                `OFF_REG56_CFG:  regRdData_d = reg56Cfg_q;
                `OFF_REG78_CFG:  regRdData_d = reg78Cfg_q;
                `OFF_BC_CTRL:    regRdData_d = bcCtrl_q;
                `OFF_SB_CTRL:    regRdData_d = sbCtrl_q;
                `OFF_IN_LOW:     regRdData_d = inLow;
                `OFF_IN_HIGH:    regRdData_d = inHigh;
                default:         regRdData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gpio9Cfg_q  <= `RST_CFG;
            gpio0Cfg_q  <= `RST_CFG;
            gpio12Cfg_q <= `RST_CFG;
            gpio3Cfg_q  <= `RST_CFG;
            reg56Cfg_q  <= `RST_CFG;
            reg78Cfg_q  <= `RST_CFG;
            bcCtrl_q    <= `RST_CTRL;
            sbCtrl_q    <= `RST_CTRL;
            regRdData_q <= 8'h00;
        end
        else
        begin
            gpio9Cfg_q  <= gpio9Cfg_d;
            gpio0Cfg_q  <= gpio0Cfg_d;
            gpio12Cfg_q <= gpio12Cfg_d;
            gpio3Cfg_q  <= gpio3Cfg_d;
            reg56Cfg_q  <= reg56Cfg_d;
            reg78Cfg_q  <= reg78Cfg_d;
            bcCtrl_q    <= bcCtrl_d;
            sbCtrl_q    <= sbCtrl_d;
            regRdData_q <= regRdData_d;
        end
    end

    assign regRdData = regRdData_q;

    ////////////////////////////////////////////////////////////////////////
    // local gpios: pin drive and input levels, never put on the link

    logic [3:0] pinCfg [10];

    assign pinCfg[0] = gpio0Cfg_q[3:0];
    assign pinCfg[1] = gpio12Cfg_q[3:0];
    assign pinCfg[2] = gpio12Cfg_q[7:4];
    assign pinCfg[3] = gpio3Cfg_q[3:0];
    assign pinCfg[4] = 4'h0;                 // no pin four
    assign pinCfg[5] = reg56Cfg_q[3:0];
    assign pinCfg[6] = reg56Cfg_q[7:4];
    assign pinCfg[7] = reg78Cfg_q[3:0];
    assign pinCfg[8] = reg78Cfg_q[7:4];
    assign pinCfg[9] = gpio9Cfg_q[3:0];

    // per-pin decode of the configuration nibble
    for (genvar g = 0; g < 10; g++)
    begin : gPin
        logic isLow, isHigh, isIn;
        assign isLow          = (pinCfg[g] == `CFG_OUT_LOW);
        assign isHigh         = (pinCfg[g] == `CFG_OUT_HIGH);
        assign isIn           = (pinCfg[g] == `CFG_INPUT);
        assign gpioPinOut[g]  = isHigh;
        assign gpioPinOe_n[g] = !(isLow || isHigh);
        assign inLvl[g]       = isIn & gpioLvl[g];
    end

    assign inLow  = {inLvl[7:5], 1'b0, inLvl[3:0]};
    assign inHigh = {6'h00, inLvl[9], inLvl[8]};

    // shared audio inputs are blocked once the pin is in a gpio mode
    for (genvar a = 0; a < 4; a++)
    begin : gAudio
        assign audioDataOut[a] = (pinCfg[a+5] == 4'h0) ? gpioLvl[a+5] : 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // mode decode and back-channel bit timing

    sb_mode_t   mode;
    logic       fwdOn, revOn;
    logic [1:0] divEnd;
    logic [4:0] sampInt;

    assign mode   = sb_mode_t'(sbCtrl_q[2:0]);
    assign fwdOn  = twoLaneMode && (mode == SB_SPI_FWD);
    assign revOn  = twoLaneMode && (mode == SB_SPI_REV);
    assign divEnd = bcCtrl_q[`BC_HIGH_RATE_BIT] ? `DIV_END_1 :
                    bcCtrl_q[`BC_RATE_SEL_BIT]  ? `DIV_END_2 : `DIV_END_4;

    // sample spacing per fast gpio mode
    always_comb
    begin
        case (mode)
            SB_FAST_4: sampInt = `SAMP_INT_4PIN;
            SB_FAST_2: sampInt = `SAMP_INT_2PIN;
            SB_FAST_1: sampInt = `SAMP_INT_1PIN;
            default:   sampInt = `SAMP_INT_NORMAL;
        endcase
    end

    logic [1:0]  divCnt_q, divCnt_d;
    logic [4:0]  bitCnt_q, bitCnt_d;
    logic [4:0]  sampCnt_q, sampCnt_d;
    logic [23:0] acc_q, acc_d;
    logic        bitTick, frameEnd, sampTick;
    logic [3:0]  fastIn;

    assign bitTick  = (divCnt_q == divEnd);
    assign frameEnd = bitTick && (bitCnt_q == `BC_FRAME_BITS - 5'd1);
    assign sampTick = bitTick && (sampCnt_q == sampInt - 5'd1);
    assign fastIn   = (twoLaneMode && !fwdOn && !revOn) ? fastLvl : 4'h0;

    // bit divider, frame counter and fast gpio sample packing
    always_comb
    begin
        divCnt_d  = bitTick ? 2'd0 : divCnt_q + 2'd1;
        bitCnt_d  = bitCnt_q;
        sampCnt_d = sampCnt_q;
        acc_d     = acc_q;
        if (bitTick)
        begin
            bitCnt_d  = frameEnd ? 5'd0 : bitCnt_q + 5'd1;
            sampCnt_d = (sampTick || frameEnd) ? 5'd0 : sampCnt_q + 5'd1;
        end
        if (sampTick)
        begin
            case (mode)
                SB_FAST_2: acc_d = {acc_q[21:0], fastIn[1:0]};
                SB_FAST_1: acc_d = {acc_q[22:0], fastIn[0]};
                default:   acc_d = {acc_q[19:0], fastIn};
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            divCnt_q  <= 2'd0;
            bitCnt_q  <= 5'd0;
            sampCnt_q <= 5'd0;
            acc_q     <= 24'h000000;
        end
        else
        begin
            divCnt_q  <= divCnt_d;
            bitCnt_q  <= bitCnt_d;
            sampCnt_q <= sampCnt_d;
            acc_q     <= frameEnd ? 24'h000000 : acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reverse spi: edge capture, buffer, one sample per frame

    logic                sclkPrev_q;
    logic [`BUF_DEPTH-1:0] mem_q, mem_d;
    logic [`BUF_AW-1:0]  wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [`BUF_AW:0]    cnt_q, cnt_d;
    logic                push, pop;
    bc_frame_t           frame_q, frame_d;
    logic                frameValid_q;

    assign push = revOn && !rSsLvl && rSclkLvl && !sclkPrev_q &&
                  (cnt_q != 4'(`BUF_DEPTH));
    assign pop  = frameEnd && revOn && (cnt_q != 4'd0);

    // buffer update and frame assembly
    always_comb
    begin
        mem_d   = mem_q;
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        cnt_d   = cnt_q;
        frame_d = frame_q;
        if (push)
        begin
            mem_d[wrPtr_q] = rMosiLvl;
            wrPtr_d        = wrPtr_q + 3'd1;
        end
        if (pop)
        begin
            rdPtr_d = rdPtr_q + 3'd1;
        end
        cnt_d = cnt_q + {3'd0, push} - {3'd0, pop};
        if (frameEnd)
        begin
            frame_d.ssLevel     = revOn ? rSsLvl : 1'b1;
            frame_d.spiValid    = pop;
            frame_d.spiMosi     = pop ? mem_q[rdPtr_q] : 1'b0;
            frame_d.gpioSamples = acc_d;
            frame_d.mode        = sbCtrl_q[2:0];
        end
        if (!revOn)
        begin
            wrPtr_d = 3'd0;
            rdPtr_d = 3'd0;
            cnt_d   = 4'd0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclkPrev_q   <= 1'b0;
            mem_q        <= '0;
            wrPtr_q      <= 3'd0;
            rdPtr_q      <= 3'd0;
            cnt_q        <= 4'd0;
            frame_q      <= '0;
            frameValid_q <= 1'b0;
        end
        else
        begin
            sclkPrev_q   <= rSclkLvl;
            mem_q        <= mem_d;
            wrPtr_q      <= wrPtr_d;
            rdPtr_q      <= rdPtr_d;
            cnt_q        <= cnt_d;
            frame_q      <= frame_d;
            frameValid_q <= frameEnd;
        end
    end

    assign bcFrame      = frame_q;
    assign bcFrameValid = frameValid_q;

    ////////////////////////////////////////////////////////////////////////
    // forward spi regeneration on recovered pixel clock edges

    logic pclkPrev_q, sclkDly_q, fSclk_q, fMosi_q, fSs_q, miso_q;
    logic sclkDly_d, fSclk_d, fMosi_d, fSs_d, pclkTick;

    assign pclkTick = pclkLvl && !pclkPrev_q;

    always_comb
    begin
        sclkDly_d = sclkDly_q;
        fSclk_d   = fSclk_q;
        fMosi_d   = fMosi_q;
        fSs_d     = fSs_q;
        if (!fwdOn)
        begin
            sclkDly_d = 1'b0;
            fSclk_d   = 1'b0;
            fMosi_d   = 1'b0;
            fSs_d     = 1'b1;
        end
        else if (pclkTick)
        begin
            sclkDly_d = fSclkLvl;
            fSclk_d   = sclkDly_q;
            fSs_d     = fSsLvl;
            if (!fSclk_q && !sclkDly_q)
            begin
                fMosi_d = fMosiLvl;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pclkPrev_q <= 1'b0;
            sclkDly_q  <= 1'b0;
            fSclk_q    <= 1'b0;
            fMosi_q    <= 1'b0;
            fSs_q      <= 1'b1;
            miso_q     <= 1'b0;
        end
        else
        begin
            pclkPrev_q <= pclkLvl;
            sclkDly_q  <= sclkDly_d;
            fSclk_q    <= fSclk_d;
            fMosi_q    <= fMosi_d;
            fSs_q      <= fSs_d;
            miso_q     <= revOn ? misoLvl : 1'b0;
        end
    end

    assign fwdSclkOut = fSclk_q;
    assign fwdMosiOut = fMosi_q;
    assign fwdSsOut_n = fSs_q;
    assign spiMisoOut = miso_q;

endmodule

`default_nettype wire

// ---- test/sideband_spi_gpio_channel_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sideband_params.svh"
module sideband_checker
    import sideband_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic [7:0] regAddr,
    input wire logic       regWr,
    input wire logic [7:0] regWrData,
    input wire logic       regRd,
    input wire logic [7:0] regRdData,
    input wire logic       twoLaneMode,
    input wire logic [9:0] gpioPinOut,
    input wire logic [9:0] gpioPinOe_n,
    input wire logic [3:0] audioDataOut,
    input wire logic       fwdSclkOut,
    input wire logic       fwdMosiOut,
    input wire logic       bcFrameValid,
    input wire bc_frame_t  bcFrame
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    logic       mapped;
    logic [7:0] oneLaneCnt_d;
    logic [7:0] oneLaneCnt_q;

    // offsets that answer a read
    assign mapped = regAddr inside {`OFF_GPIO9_CFG, `OFF_GPIO0_CFG, `OFF_GPIO12_CFG,
        `OFF_GPIO3_CFG, `OFF_REG56_CFG, `OFF_REG78_CFG, `OFF_BC_CTRL, `OFF_SB_CTRL,
        `OFF_IN_LOW, `OFF_IN_HIGH};

    // cycles spent in single-lane operation, saturating
    always_comb
    begin
        oneLaneCnt_d = (oneLaneCnt_q == 8'hff) ? oneLaneCnt_q : oneLaneCnt_q + 8'h01;
        if (twoLaneMode)
            oneLaneCnt_d = 8'h00;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            oneLaneCnt_q <= 8'h00;
        else
            oneLaneCnt_q <= oneLaneCnt_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_frame;
        bcFrameValid;
    endsequence

    sequence s_quiet;
        (!bcFrameValid) [*8];
    endsequence

    sequence s_high8_write;
        regWr && regAddr == `OFF_REG78_CFG && regWrData[7:4] == `CFG_OUT_HIGH;
    endsequence

    a_unmapped_reads_zero: assert property (regRd && !mapped |=> regRdData == 8'h00)
        else $error("unmapped read returned data");
    a_high_status_pad: assert property (regRd && regAddr == `OFF_IN_HIGH |=> regRdData[7:2] == 6'h00)
        else $error("upper status byte has stray bits");
    a_cfg_drives_high: assert property (s_high8_write |=> !gpioPinOe_n[8] && gpioPinOut[8])
        else $error("gpio8 not driven high");
    a_drive_needs_enable: assert property ((gpioPinOut & gpioPinOe_n) == 10'h000)
        else $error("pin high while not driven");
    a_audio_yields: assert property ((~gpioPinOe_n[8:5] & audioDataOut) == 4'h0)
        else $error("audio passes on a gpio pin");
    a_mosi_held_high: assert property (fwdSclkOut && $past(fwdSclkOut) |-> $stable(fwdMosiOut))
        else $error("mosi moved while sclk high");
    a_sclk_edge_setup: assert property ($changed(fwdSclkOut) |-> $stable(fwdMosiOut))
        else $error("mosi moved with sclk edge");
    a_frame_spacing: assert property (s_frame |=> s_quiet ##[1:120] s_frame)
        else $error("frame spacing out of range");
    a_spi_needs_lanes: assert property (bcFrameValid && bcFrame.spiValid |-> twoLaneMode)
        else $error("spi sample sent on one lane");
    a_single_lane_quiet: assert property (bcFrameValid && oneLaneCnt_q == 8'hff |-> bcFrame.gpioSamples == 24'h0)
        else $error("fast gpio sampled on one lane");
endmodule

bind sideband_spi_gpio_channel sideband_checker chk
(
    .core_clk, .nrst, .regAddr, .regWr, .regWrData, .regRd, .regRdData, .twoLaneMode,
    .gpioPinOut, .gpioPinOe_n, .audioDataOut, .fwdSclkOut, .fwdMosiOut, .bcFrameValid,
    .bcFrame
);
`default_nettype wire

// ---- test/remote_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module remote_link_model
    import sideband_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      nrst,
    input  wire fwd_spi_t  fwdMaster,
    input  wire logic      bcFrameValid,
    input  wire bc_frame_t bcFrame,
    output logic           pixelClkIn,
    output fwd_spi_t       fwdSpiIn,
    output logic           remoteMisoIn,
    output logic [7:0]     rxBits,
    output logic [3:0]     rxCount
);
    // free-running pixel clock, phase unrelated to the core clock
    initial
    begin
        pixelClkIn = 1'b0;
        #137;
        forever #200 pixelClkIn = ~pixelClkIn;
    end

    // far end oversamples its spi master on the pixel clock
    always @(posedge pixelClkIn)
        fwdSpiIn <= fwdMaster;

    // back-channel receiver: collect spi bits, echo the last as miso
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rxBits <= 8'h00;
            rxCount <= 4'h0;
            remoteMisoIn <= 1'b0;
        end
        else if (bcFrameValid && bcFrame.spiValid)
        begin
            rxBits <= {rxBits[6:0], bcFrame.spiMosi};
            rxCount <= rxCount + 4'h1;
            remoteMisoIn <= bcFrame.spiMosi;
        end
    end
endmodule
`default_nettype wire

// ---- test/sideband_spi_gpio_channel_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin badCount++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module sideband_spi_gpio_channel_test
    import sideband_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic       regWr = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic       regRd = 1'b0;
    logic [7:0] regRdData;
    logic       twoLaneMode = 1'b1;
    logic [9:0] gpioPinIn = 10'h000;
    logic [9:0] gpioPinOut;
    logic [9:0] gpioPinOe_n;
    logic [3:0] audioDataOut;
    logic [3:0] fastGpioIn = 4'h0;
    logic       pixelClkIn;
    fwd_spi_t   fwdSpiIn;
    fwd_spi_t   fwdMaster = 3'b001;
    logic       fwdSclkOut;
    logic       fwdMosiOut;
    logic       fwdSsOut_n;
    logic       spiSsIn_n = 1'b1;
    logic       spiSclkIn = 1'b0;
    logic       spiMosiIn = 1'b0;
    logic       remoteMisoIn;
    logic       spiMisoOut;
    logic       bcFrameValid;
    bc_frame_t  bcFrame;
    logic [7:0] rxBits;
    logic [3:0] rxCount;
    logic [7:0] fwdRx = 8'h00;
    int         fwdCnt = 0;
    int         badCount = 0;
    int         checked = 0;

    always #25 core_clk = ~core_clk;

    sideband_spi_gpio_channel dut
    (
        .core_clk, .nrst, .regAddr, .regWr, .regWrData, .regRd, .regRdData, .twoLaneMode,
        .gpioPinIn, .gpioPinOut, .gpioPinOe_n, .audioDataOut, .fastGpioIn, .pixelClkIn,
        .fwdSpiIn, .fwdSclkOut, .fwdMosiOut, .fwdSsOut_n, .spiSsIn_n, .spiSclkIn,
        .spiMosiIn, .remoteMisoIn, .spiMisoOut, .bcFrameValid, .bcFrame
    );

    remote_link_model partner
    (
        .core_clk, .nrst, .fwdMaster, .bcFrameValid, .bcFrame, .pixelClkIn, .fwdSpiIn,
        .remoteMisoIn, .rxBits, .rxCount
    );

    // regenerated forward mosi, taken at each rising sclk
    always @(posedge fwdSclkOut)
    begin
        fwdRx <= {fwdRx[6:0], fwdMosiOut};
        fwdCnt <= fwdCnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stopTest();
        if (badCount == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(negedge core_clk);
        regWr = 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        regAddr = a;
        regRd = 1'b1;
        @(negedge core_clk);
        regRd = 1'b0;
        @(negedge core_clk);
        `CHK(regRdData, e)
    endtask

    task automatic waitFrame(output int n);
        n = 0;
        while (bcFrameValid !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 400)
            badCount++;
        @(negedge core_clk);
    endtask

    task automatic testRegs();
        logic [7:0] offs [7] = '{8'h1a, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h43};
        foreach (offs[i]) rdChk(offs[i], 8'h00);
        wr(8'h1d, 8'h09);
        rdChk(8'h1d, 8'h09);
        wr(8'h6e, 8'hff);
        rdChk(8'h6e, 8'h00);
        rdChk(8'h55, 8'h00);
    endtask

    task automatic testOutputs();
        gpioPinIn = 10'h1c0;
        repeat (8) @(negedge core_clk);
        `CHK(audioDataOut, 4'he)
        wr(8'h20, 8'h11);
        wr(8'h21, 8'h90);
        wr(8'h1a, 8'h09);
        repeat (8) @(negedge core_clk);
        `CHK(audioDataOut, 4'h4)
        `CHK(gpioPinOe_n, 10'h09e)
        `CHK(gpioPinOut, 10'h301)
        rdChk(8'h21, 8'h90);
    endtask

    task automatic testInputs();
        logic [7:0] offs [6] = '{8'h1a, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21};
        logic [7:0] vals [6] = '{8'h03, 8'h03, 8'h33, 8'h03, 8'h33, 8'h33};
        logic [9:0] pins [2] = '{10'h2ad, 10'h152};
        foreach (offs[i]) wr(offs[i], vals[i]);
        `CHK(gpioPinOe_n, 10'h3ff)
        foreach (pins[i])
        begin
            gpioPinIn = pins[i];
            repeat (8) @(negedge core_clk);
            rdChk(8'h6e, {pins[i][7:5], 1'b0, pins[i][3:0]});
            rdChk(8'h6f, {6'h00, pins[i][9:8]});
        end
    endtask

    task automatic testRate();
        logic [7:0] ctl [4] = '{8'h00, 8'h40, 8'h10, 8'h50};
        int         per [4] = '{120, 60, 30, 30};
        int         n;
        foreach (ctl[i])
        begin
            wr(8'h23, ctl[i]);
            repeat (2) waitFrame(n);
            waitFrame(n);
            `CHK(n + 1, per[i])
        end
    endtask

    task automatic testFast();
        logic [2:0]  md [4] = '{3'h0, 3'h3, 3'h2, 3'h1};
        logic [23:0] msk [4] = '{24'h00000f, 24'hffffff, 24'h0fffff, 24'h007fff};
        logic [23:0] want [4] = '{24'h000005, 24'h555555, 24'h055555, 24'h007fff};
        int          n;
        fastGpioIn = 4'h5;
        foreach (md[i])
        begin
            wr(8'h43, {5'h00, md[i]});
            repeat (2) waitFrame(n);
            `CHK(bcFrame.gpioSamples & msk[i], want[i])
            `CHK(bcFrame.mode, md[i])
        end
        twoLaneMode = 1'b0;
        repeat (10) waitFrame(n);
        `CHK(bcFrame.gpioSamples, 24'h000000)
        twoLaneMode = 1'b1;
    endtask

    task automatic testReverse();
        logic [2:0] bits = 3'b101;
        int         n;
        wr(8'h43, 8'h07);
        repeat (2) waitFrame(n);
        spiSsIn_n = 1'b0;
        // bits come faster than frames drain them
        for (int i = 2; i >= 0; i--)
        begin
            spiMosiIn = bits[i];
            repeat (10) @(negedge core_clk);
            spiSclkIn = 1'b1;
            repeat (10) @(negedge core_clk);
            spiSclkIn = 1'b0;
        end
        repeat (3) waitFrame(n);
        `CHK(bcFrame.ssLevel, 1'b0)
        spiSsIn_n = 1'b1;
        repeat (3) waitFrame(n);
        `CHK(bcFrame.ssLevel, 1'b1)
        `CHK(rxCount, 4'h3)
        `CHK(rxBits[2:0], bits)
        `CHK(spiMisoOut, 1'b1)
        wr(8'h43, 8'h00);
        repeat (8) @(negedge core_clk);
        `CHK(spiMisoOut, 1'b0)
    endtask

    task automatic testForward();
        logic [7:0] dat = 8'hc5;
        int         c0;
        c0 = fwdCnt;
        fwdMaster = 3'b100;
        repeat (24) @(negedge core_clk);
        `CHK(fwdCnt, c0)
        fwdMaster = 3'b001;
        repeat (24) @(negedge core_clk);
        wr(8'h43, 8'h06);
        fwdMaster.ss_n = 1'b0;
        // write only: fast clock, miso left unread
        for (int i = 7; i >= 0; i--)
        begin
            fwdMaster.mosi = dat[i];
            repeat (24) @(negedge core_clk);
            fwdMaster.sclk = 1'b1;
            repeat (24) @(negedge core_clk);
            fwdMaster.sclk = 1'b0;
        end
        `CHK(fwdSsOut_n, 1'b0)
        repeat (24) @(negedge core_clk);
        fwdMaster.ss_n = 1'b1;
        repeat (40) @(negedge core_clk);
        `CHK(fwdSsOut_n, 1'b1)
        `CHK(fwdRx, dat)
        `CHK(fwdCnt - c0, 8)
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(negedge core_clk);
        nrst = 1'b1;
        testRegs();
        testOutputs();
        testInputs();
        testRate();
        testFast();
        testReverse();
        testForward();
        stopTest();
    end

    // watchdog: tests need about 2200 cycles, allow 20000
    initial
    begin
        #1000000;
        badCount++;
        stopTest();
    end
endmodule
`default_nettype wire
